// *** design/okc_pkg.sv ***
package okc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses on the APB
  // ----------------------------------------------------------------
  localparam logic [15:0] OKC_ADDR_KEY      = 16'h0a0c;  // Unlock word for the control register
  localparam logic [15:0] OKC_ADDR_CTRL     = 16'h0a10;  // Oscillator enables and ready flags
  localparam logic [15:0] OKC_ADDR_FASTCFG  = 16'h20bc;  // Fast output rate selection
  localparam logic [15:0] OKC_ADDR_DIVCFG   = 16'h0408;  // System clock divider
  localparam logic [15:0] OKC_ADDR_IRQ_STS  = 16'h0a80;  // Sticky event status, write one to clear
  localparam logic [15:0] OKC_ADDR_IRQ_MSK  = 16'h0a84;  // Event mask, one lets the event through

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int          OKC_NUM_OSC       = 3;         // Slow, fast internal, crystal
  localparam int          OKC_EN_LSB        = 0;         // Enables sit in bits 2:0
  localparam int          OKC_RDY_LSB       = 8;         // Ready flags sit in bits 10:8
  localparam int          OKC_RATE_BIT      = 2;         // Fast output select, 1 means 16 MHz
  localparam int          OKC_DIV_W         = 6;         // Divider field width
  localparam int          OKC_EVT_W         = 4;         // Three ready events and a refused write
  localparam logic [15:0] OKC_UNLOCK_WORD   = 16'hcb14;  // Value that opens the control register
  localparam logic [2:0]  OKC_EN_RST        = 3'h3;      // Both internal oscillators run from reset
  localparam logic [31:0] OKC_FASTCFG_RST   = 32'h00000034;
  localparam logic [15:0] OKC_DIVCFG_RST    = 16'h0441;
  localparam logic [5:0]  OKC_DIV_MAX       = 6'h20;     // Divider saturates at 32

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          OKC_CLK_NS        = 20;        // 50 MHz block clock
  localparam int          OKC_SETTLE_NS     = 10000;     // Least settling time after enable
  localparam int          OKC_SETTLE_CYC    = (OKC_SETTLE_NS + OKC_CLK_NS - 1) / OKC_CLK_NS;

  // ----------------------------------------------------------------
  // APB request bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;     // Slave selected
    logic        penable;  // Access phase
    logic        pwrite;   // Write when high
    logic [15:0] paddr;    // Byte address
    logic [31:0] pwdata;   // Write data
  } okc_apb_req_t;

endpackage

// *** design/okc_settle.sv ***
`timescale 1ns/10ps
module okc_settle #(
  parameter int SETTLE_CYC = 500
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,      // Oscillator enable
  input  wire logic stable_i,  // Synchronised stability level
  output logic      ready_o    // Ready flag, low at once when disabled
);
  import okc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (SETTLE_CYC < 2 || SETTLE_CYC > 65535)
  begin : g_bad_settle
    $error("okc_settle: settle count out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] cnt_ff;    // Cycles since enable
    logic        ready_ff;  // Latched ready
  } okc_settle_st_t;

  okc_settle_st_t st_ff;
  okc_settle_st_t nxt_st;

  // Counter starts on enable, flag latches once settled and stable
  always_comb
  begin
    nxt_st = st_ff;
    if (!en_i)
    begin
      nxt_st.cnt_ff   = '0;
      nxt_st.ready_ff = 1'b0;
    end
    else
    begin
      if (nxt_st.cnt_ff != 16'(SETTLE_CYC))
        nxt_st.cnt_ff = st_ff.cnt_ff + 16'h0001;
      // Once set, a later drop of stable_i is ignored on purpose
      if (st_ff.cnt_ff == 16'(SETTLE_CYC) && stable_i)
        nxt_st.ready_ff = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // Gating by enable clears the flag in the very cycle of disable
  assign ready_o = st_ff.ready_ff & en_i;

endmodule

// *** design/okc_top.sv ***
`timescale 1ns/10ps
module okc_top #(
  parameter int SETTLE_CYC = okc_pkg::OKC_SETTLE_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire okc_pkg::okc_apb_req_t apb_i,
  output logic [31:0]               prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  input  wire logic [2:0]           osc_stable_i,
  output logic [2:0]                osc_enable_o,
  output logic [2:0]                osc_ready_o,
  output logic                      fast_rate_32_o,
  output logic                      sys_clk_tick_o,
  output logic                      irq_o
);
  import okc_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (SETTLE_CYC < 2)
  begin : g_bad_top
    $error("okc_top: settle count too small");
  end

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  unlock_ff;  // Control register open for one write
    logic [15:0]           key_ff;     // Last word written to the key register
    logic [2:0]            en_ff;      // Oscillator enables
    logic                  rate16_ff;  // Fast output at 16 MHz when high
    logic [OKC_DIV_W-1:0]  div_ff;     // Divider field
    logic [OKC_EVT_W-1:0]  sts_ff;     // Sticky events
    logic [OKC_EVT_W-1:0]  msk_ff;     // Event mask
    logic                  rsp_ff;     // Answer phase of an APB access
    logic                  err_ff;     // Unmapped address answer
    logic [31:0]           rdata_ff;   // Read data
    logic [2:0]            sync1_ff;   // First synchroniser stage
    logic [2:0]            sync2_ff;   // Second synchroniser stage
    logic [2:0]            rdy_q_ff;   // Ready flags one cycle back
    logic [OKC_DIV_W-1:0]  tcnt_ff;    // System tick counter
    logic                  tick_ff;    // System tick
  } okc_state_t;

  okc_state_t st_ff;
  okc_state_t nxt_st;

  logic [2:0] rdy_w;    // Ready flags from the settle counters
  logic       acc_w;    // Access phase seen by the slave
  logic       wr_w;     // Write taken at this edge
  logic       hit_w;    // Address decodes to a register
  logic [5:0] eff_w;    // Effective division

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Divider field to division ratio; 32 MHz source forces at least two
  function automatic logic [5:0] okc_div_eff(input logic [5:0] d, input logic fast32);
    logic [5:0] r;
    r = d;
    if (d > OKC_DIV_MAX)
      r = OKC_DIV_MAX;
    else if (d < 6'h02)
      r = 6'h01;
    if (fast32 && r < 6'h02)
      r = 6'h02;
    return r;
  endfunction

  // Address decode for the error path; the read path decodes with its own case
  function automatic logic okc_mapped(input logic [15:0] a);
    return (a == OKC_ADDR_KEY) || (a == OKC_ADDR_CTRL) || (a == OKC_ADDR_FASTCFG) ||
           (a == OKC_ADDR_DIVCFG) || (a == OKC_ADDR_IRQ_STS) || (a == OKC_ADDR_IRQ_MSK);
  endfunction

  // ----------------------------------------------------------------
  // Settling counters, one per oscillator
  // ----------------------------------------------------------------
  for (genvar i = 0; i < OKC_NUM_OSC; i++)
  begin : g_settle
    okc_settle #(
      .SETTLE_CYC (SETTLE_CYC)
    ) u_settle (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .en_i     (st_ff.en_ff[i]),
      .stable_i (st_ff.sync2_ff[i]),
      .ready_o  (rdy_w[i])
    );
  end

  assign acc_w = apb_i.psel & apb_i.penable;
  assign wr_w  = acc_w & st_ff.rsp_ff & apb_i.pwrite;
  assign hit_w = okc_mapped(apb_i.paddr);
  assign eff_w = okc_div_eff(st_ff.div_ff, ~st_ff.rate16_ff);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;

    // Pin levels pass two flops before use
    nxt_st.sync1_ff = osc_stable_i;
    nxt_st.sync2_ff = st_ff.sync1_ff;
    nxt_st.rdy_q_ff = rdy_w;

    // One wait state: data is registered, then pready rises
    nxt_st.rsp_ff = acc_w & ~st_ff.rsp_ff;
    if (acc_w && !st_ff.rsp_ff)
    begin
      nxt_st.err_ff   = ~hit_w;
      nxt_st.rdata_ff = 32'h00000000;
      if (!apb_i.pwrite)
      begin
        unique case (apb_i.paddr)
          OKC_ADDR_KEY:     nxt_st.rdata_ff = {16'h0000, st_ff.key_ff};
          // Ready flags and enables
          OKC_ADDR_CTRL:    nxt_st.rdata_ff = {21'h000000, rdy_w, 5'h00, st_ff.en_ff};
          // Reserved bits read their reset pattern
          OKC_ADDR_FASTCFG: nxt_st.rdata_ff = (OKC_FASTCFG_RST & ~32'h00000004) |
                                              {29'h00000000, st_ff.rate16_ff, 2'h0};
          OKC_ADDR_DIVCFG:  nxt_st.rdata_ff = {16'h0000, OKC_DIVCFG_RST[15:6], st_ff.div_ff};
          OKC_ADDR_IRQ_STS: nxt_st.rdata_ff = {28'h0000000, st_ff.sts_ff};
          OKC_ADDR_IRQ_MSK: nxt_st.rdata_ff = {28'h0000000, st_ff.msk_ff};
          default:          nxt_st.rdata_ff = 32'h00000000;
        endcase
      end
    end

    // Register writes take effect at the edge that sees pready high
    if (wr_w)
    begin
      // Any write elsewhere closes the protection again
      nxt_st.unlock_ff = 1'b0;
      unique case (apb_i.paddr)
        OKC_ADDR_KEY:
        begin
          nxt_st.key_ff    = apb_i.pwdata[15:0];
          nxt_st.unlock_ff = (apb_i.pwdata[15:0] == OKC_UNLOCK_WORD);
        end
        OKC_ADDR_CTRL:
        begin
          // Writes while locked are dropped and flagged
          if (st_ff.unlock_ff)
            nxt_st.en_ff = apb_i.pwdata[2:0];
          else
            nxt_st.sts_ff[3] = 1'b1;
        end
        OKC_ADDR_FASTCFG: nxt_st.rate16_ff = apb_i.pwdata[OKC_RATE_BIT];
        OKC_ADDR_DIVCFG:  nxt_st.div_ff    = apb_i.pwdata[OKC_DIV_W-1:0];
        OKC_ADDR_IRQ_STS: nxt_st.sts_ff    = st_ff.sts_ff & ~apb_i.pwdata[OKC_EVT_W-1:0];
        OKC_ADDR_IRQ_MSK: nxt_st.msk_ff    = apb_i.pwdata[OKC_EVT_W-1:0];
        default:          nxt_st.key_ff    = st_ff.key_ff;
      endcase
    end

    // Rising ready flags set sticky status; set beats a clear
    nxt_st.sts_ff[2:0] = nxt_st.sts_ff[2:0] | (rdy_w & ~st_ff.rdy_q_ff);

    // System tick: counter wraps at the effective ratio
    if (st_ff.tcnt_ff + 6'h01 >= eff_w)
    begin
      nxt_st.tcnt_ff = 6'h00;
      nxt_st.tick_ff = 1'b1;
    end
    else
    begin
      nxt_st.tcnt_ff = st_ff.tcnt_ff + 6'h01;
      nxt_st.tick_ff = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff           <= '0;
      st_ff.en_ff     <= OKC_EN_RST;
      st_ff.rate16_ff <= OKC_FASTCFG_RST[OKC_RATE_BIT];
      st_ff.div_ff    <= OKC_DIVCFG_RST[OKC_DIV_W-1:0];
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata_o       = st_ff.rdata_ff;
  assign pready_o       = st_ff.rsp_ff;
  assign pslverr_o      = st_ff.rsp_ff & st_ff.err_ff;
  assign osc_enable_o   = st_ff.en_ff;
  assign osc_ready_o    = rdy_w;
  // Converter may take this rate directly; system tick never runs undivided from it
  assign fast_rate_32_o = ~st_ff.rate16_ff;
  assign sys_clk_tick_o = st_ff.tick_ff;
  assign irq_o          = |(st_ff.sts_ff & st_ff.msk_ff);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_other_write;
    wr_w && apb_i.paddr != OKC_ADDR_CTRL && apb_i.paddr != OKC_ADDR_KEY;
  endsequence

  sequence s_locked_ctrl;
    wr_w && apb_i.paddr == OKC_ADDR_CTRL && !st_ff.unlock_ff;
  endsequence

  sequence s_xtal_on;
    $rose(st_ff.en_ff[2]);
  endsequence

  a_relock_other: assert property (@(posedge clk_i) disable iff (rst_i)
    s_other_write |=> !st_ff.unlock_ff)
    else $error("protection stayed open after another write");

  a_locked_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_locked_ctrl |=> st_ff.en_ff == $past(st_ff.en_ff) && st_ff.sts_ff[3])
    else $error("locked control write changed enables");

  a_xtal_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    osc_ready_o[2] |-> osc_enable_o[2])
    else $error("crystal ready while disabled");

  a_fast_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    osc_ready_o[1] |-> osc_enable_o[1])
    else $error("fast ready while disabled");

  a_slow_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    osc_ready_o[0] |-> osc_enable_o[0])
    else $error("slow ready while disabled");

  a_ready_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (osc_ready_o[2] && osc_enable_o[2]) ##1 osc_enable_o[2] |-> osc_ready_o[2])
    else $error("ready flag dropped while enabled");

  a_enable_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> osc_enable_o == 3'h3)
    else $error("enable reset value wrong");

  a_rate_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w && apb_i.paddr == OKC_ADDR_FASTCFG |=> fast_rate_32_o == !$past(apb_i.pwdata[2]))
    else $error("rate select did not follow write");

  a_sys_not32: assert property (@(posedge clk_i) disable iff (rst_i)
    fast_rate_32_o && $past(fast_rate_32_o) && sys_clk_tick_o |=> !sys_clk_tick_o)
    else $error("system tick ran undivided at 32 MHz");

  // The release edge is left out: the tick register still holds its reset zero there
  a_div_one: assert property (@(posedge clk_i) disable iff (rst_i)
    (eff_w == 6'h01 && !rst_i) [*2] |-> sys_clk_tick_o)
    else $error("divide by one did not tick every cycle");

  a_settle_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    s_xtal_on |-> !osc_ready_o[2] [*2])
    else $error("crystal ready without settling");

  // ----------------------------------------------------------------
  // Bus, key, divider and event checks
  // ----------------------------------------------------------------
  // First access cycle of a transfer, before the wait state ends
  sequence s_acc_first;
    acc_w && !pready_o;
  endsequence

  // Open control write, the only path that may move the enables
  sequence s_open_ctrl;
    wr_w && apb_i.paddr == OKC_ADDR_CTRL && st_ff.unlock_ff;
  endsequence

  a_one_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    s_acc_first |=> pready_o)
    else $error("access did not end after one wait state");

  a_pready_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    pready_o |=> !pready_o)
    else $error("ready held longer than one cycle");

  a_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    s_acc_first ##0 !hit_w |=> pslverr_o && prdata_o == 32'h00000000)
    else $error("unmapped access not refused");

  a_ok_mapped: assert property (@(posedge clk_i) disable iff (rst_i)
    s_acc_first ##0 hit_w |=> !pslverr_o)
    else $error("mapped access refused");

  a_unlock_key: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w && apb_i.paddr == OKC_ADDR_KEY && apb_i.pwdata[15:0] == OKC_UNLOCK_WORD |=> st_ff.unlock_ff)
    else $error("unlock word did not open control register");

  a_bad_key: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w && apb_i.paddr == OKC_ADDR_KEY && apb_i.pwdata[15:0] != OKC_UNLOCK_WORD |=> !st_ff.unlock_ff)
    else $error("wrong key opened control register");

  a_open_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_open_ctrl |=> osc_enable_o == $past(apb_i.pwdata[2:0]) && !st_ff.unlock_ff)
    else $error("open control write not applied");

  a_enable_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_w && apb_i.paddr == OKC_ADDR_CTRL && st_ff.unlock_ff) |=> $stable(osc_enable_o))
    else $error("enables moved without an open control write");

  a_fast_floor: assert property (@(posedge clk_i) disable iff (rst_i)
    fast_rate_32_o |-> eff_w >= 6'h02)
    else $error("system ratio below two at 32 MHz");

  a_div_sat: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.div_ff > OKC_DIV_MAX |-> eff_w == OKC_DIV_MAX)
    else $error("divider did not saturate");

  a_slow_event: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(osc_ready_o[0]) |=> st_ff.sts_ff[0])
    else $error("slow ready event not recorded");

  a_xtal_event: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(osc_ready_o[2]) |=> st_ff.sts_ff[2])
    else $error("crystal ready event not recorded");

  a_clear_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_w && apb_i.paddr == OKC_ADDR_IRQ_STS && apb_i.pwdata[3] |=> !st_ff.sts_ff[3])
    else $error("refused write status not cleared");

endmodule

// *** verification/okc_top_tb.sv ***
`timescale 1ns/10ps
module okc_top_tb;
  import okc_pkg::*;

  // ----------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------
  localparam int SETTLE = 4;          // Short settling count keeps the run brief
  logic          clk_i;               // Block clock, 50 MHz
  logic          rst_i;               // Synchronous reset, active high
  okc_apb_req_t  apb_req;             // APB request bundle
  logic [31:0]   prdata_o;            // Read data
  logic          pready_o;            // Access complete
  logic          pslverr_o;           // Refused access
  logic [2:0]    osc_stable_i;        // Raw stability levels
  logic [2:0]    osc_enable_o;        // Oscillator enables
  logic [2:0]    osc_ready_o;         // Ready flags
  logic          fast_rate_32_o;      // Fast output at 32 MHz
  logic          sys_clk_tick_o;      // System clock tick
  logic          irq_o;               // Interrupt level
  int            errors;              // Mismatches seen
  int            checked;             // Comparisons made
  int            seed;                // Fixed seed keeps runs repeatable
  logic [31:0]   rdat;                // Last read data
  logic          rerr;                // Last error response
  logic [5:0]    divs [8];            // Divider values to try

  okc_top #(.SETTLE_CYC(SETTLE)) dut (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .apb_i          (apb_req),
    .prdata_o       (prdata_o),
    .pready_o       (pready_o),
    .pslverr_o      (pslverr_o),
    .osc_stable_i   (osc_stable_i),
    .osc_enable_o   (osc_enable_o),
    .osc_ready_o    (osc_ready_o),
    .fast_rate_32_o (fast_rate_32_o),
    .sys_clk_tick_o (sys_clk_tick_o),
    .irq_o          (irq_o)
  );

  // Free-running clock
  always #10 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count; four-state match so unknowns fail
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb_xfer(input logic wr, input logic [15:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge clk_i);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk_i);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    rdat = prdata_o;
    rerr = pslverr_o;
    if (n >= 20)
      chk(32'h0, 32'h1);
    apb_req <= '0;
  endtask

  task automatic wr(input logic [15:0] addr, input logic [31:0] d);
    apb_xfer(1'b1, addr, d);
  endtask

  task automatic rd_chk(input logic [15:0] addr, input logic [31:0] exp);
    apb_xfer(1'b0, addr, 32'h0);
    chk(rdat, exp);
  endtask

  // Effective system divider as software should see it
  function automatic int eff_div(input logic [5:0] d, input logic fast32);
    int r;
    r = (d <= 6'h1) ? 1 : (d > 6'h20) ? 32 : int'(d);
    if (fast32 && r < 2)
      r = 2;
    return r;
  endfunction

  // Program a divider, let the phase settle, count ticks over eight periods
  task automatic tick_chk(input logic [5:0] d, input logic fast32);
    int cnt;
    int p;
    cnt = 0;
    p = eff_div(d, fast32);
    wr(OKC_ADDR_DIVCFG, {26'h0, d});
    rd_chk(OKC_ADDR_DIVCFG, 32'h0440 | {26'h0, d});
    repeat (40) @(posedge clk_i);
    repeat (p * 8)
    begin
      @(posedge clk_i);
      if (sys_clk_tick_o === 1'b1)
        cnt++;
    end
    chk(cnt, 32'd8);
  endtask

  // Print counts and verdict, then stop
  task automatic test_done;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog sized well beyond the expected run
  initial
  begin
    #(20 * 60000);
    errors++;
    $display("watchdog expired");
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    apb_req = '0;
    osc_stable_i = 3'h0;
    errors = 0;
    checked = 0;
    seed = 32'h04c0604d;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values
    rd_chk(OKC_ADDR_CTRL, 32'h3);
    rd_chk(OKC_ADDR_FASTCFG, 32'h34);
    rd_chk(OKC_ADDR_KEY, 32'h0);
    chk(fast_rate_32_o, 1'b0);
    $display("test reset done");
    // Locked write with random data must not move the enables
    wr(OKC_ADDR_CTRL, $random(seed) | 32'h4);
    chk(osc_enable_o, 3'h3);
    wr(OKC_ADDR_KEY, OKC_UNLOCK_WORD);
    wr(16'h0ffc, 32'h0);
    chk(rerr, 1'b1);
    wr(OKC_ADDR_CTRL, 32'h4);
    rd_chk(OKC_ADDR_CTRL, 32'h3);
    $display("test lock done");
    // Unlocked write enables all three; nothing is ready yet
    wr(OKC_ADDR_KEY, OKC_UNLOCK_WORD);
    wr(OKC_ADDR_CTRL, 32'h7);
    @(posedge clk_i);
    chk(osc_enable_o, 3'h7);
    chk(osc_ready_o, 3'h0);
    osc_stable_i <= 3'h7;
    for (int i = 0; i < 40 && osc_ready_o !== 3'h7; i++)
      @(posedge clk_i);
    chk(osc_ready_o, 3'h7);
    rd_chk(OKC_ADDR_CTRL, 32'h707);
    // Losing stability later leaves the flags alone
    osc_stable_i <= 3'h0;
    repeat (10) @(posedge clk_i);
    rd_chk(OKC_ADDR_CTRL, 32'h707);
    $display("test ready done");
    // Interrupts: three ready events plus the flag of the two refused writes
    rd_chk(OKC_ADDR_IRQ_STS, 32'hf);
    chk(irq_o, 1'b0);
    wr(OKC_ADDR_IRQ_MSK, 32'h8);
    @(posedge clk_i);
    chk(irq_o, 1'b1);
    wr(OKC_ADDR_IRQ_STS, 32'h8);
    @(posedge clk_i);
    chk(irq_o, 1'b0);
    rd_chk(OKC_ADDR_IRQ_STS, 32'h7);
    wr(OKC_ADDR_IRQ_MSK, 32'h0);
    $display("test irq done");
    // Disabling the crystal drops its flag at once
    wr(OKC_ADDR_KEY, OKC_UNLOCK_WORD);
    wr(OKC_ADDR_CTRL, 32'h3);
    @(posedge clk_i);
    chk(osc_ready_o, 3'h3);
    rd_chk(OKC_ADDR_CTRL, 32'h303);
    apb_xfer(1'b0, 16'h0ffc, 32'h0);
    chk({rerr, rdat}, {1'b1, 32'h0});
    $display("test disable done");
    // Divider corners and random values
    divs = '{6'h0, 6'h1, 6'h2, 6'h20, 6'h21, 6'h3f, 6'h0, 6'h0};
    divs[6] = 6'($random(seed));
    divs[7] = 6'($random(seed));
    foreach (divs[i])
      tick_chk(divs[i], 1'b0);
    $display("test divider done");
    // Fast output at 32 MHz after halving the system clock
    wr(OKC_ADDR_DIVCFG, 32'h2);
    wr(OKC_ADDR_FASTCFG, 32'h0);
    @(posedge clk_i);
    chk(fast_rate_32_o, 1'b1);
    rd_chk(OKC_ADDR_FASTCFG, 32'h30);
    tick_chk(6'h1, 1'b1);
    wr(OKC_ADDR_FASTCFG, 32'h4);
    rd_chk(OKC_ADDR_FASTCFG, 32'h34);
    $display("test fast rate done");
    // Wrong key keeps the lock
    wr(OKC_ADDR_KEY, 32'h0000a5a5);
    wr(OKC_ADDR_CTRL, 32'h4);
    rd_chk(OKC_ADDR_CTRL, 32'h303);
    // Both fast sources on, then a reset request in mid-run
    wr(OKC_ADDR_KEY, OKC_UNLOCK_WORD);
    wr(OKC_ADDR_CTRL, 32'h7);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OKC_ADDR_CTRL, 32'h3);
    rd_chk(OKC_ADDR_IRQ_STS, 32'h0);
    rd_chk(OKC_ADDR_DIVCFG, 32'h441);
    chk({irq_o, fast_rate_32_o}, 2'h0);
    $display("test reset request done");
    test_done();
  end
endmodule
